/* File: inc/ssf_pkg.sv */
// Package: register map, field positions and reset values of the status-flag block
package ssf_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [15:0] SSF_IDX_CFG     = 16'h7040;
	localparam logic [15:0] SSF_IDX_OPC     = 16'h7041;
	localparam logic [15:0] SSF_IDX_STS     = 16'h7042;
	localparam logic [15:0] SSF_IDX_RXB     = 16'h7047;
	localparam logic [15:0] SSF_IDX_TXB     = 16'h7048;
	localparam logic [15:0] SSF_IDX_IRQ_STS = 16'h7050;
	localparam logic [15:0] SSF_IDX_IRQ_MSK = 16'h7051;

	// Field positions
	localparam int SSF_CFG_SRST_BIT = 7;
	localparam int SSF_OPC_OVR_EN   = 4;
	localparam int SSF_OPC_XFER_EN  = 0;
	localparam int SSF_STS_OVR      = 7;
	localparam int SSF_STS_XFER     = 6;
	localparam int SSF_STS_TXF      = 5;
	localparam int SSF_IRQ_XFER     = 0;
	localparam int SSF_IRQ_OVR      = 1;

	// Character length and widths
	localparam int SSF_CHAR_BITS = 8;
	localparam int SSF_IRQ_BITS  = 2;

	// Reset values
	localparam logic [7:0]              SSF_CFG_RST  = 8'h00;
	localparam logic [7:0]              SSF_OPC_RST  = 8'h00;
	localparam logic [7:0]              SSF_BUF_RST  = 8'h00;
	localparam logic [SSF_IRQ_BITS-1:0] SSF_MSK_RST  = 2'h3;
	localparam logic [SSF_IRQ_BITS-1:0] SSF_ISTS_RST = 2'h0;

	// Byte address of a register index
	function automatic logic [31:0] ssf_addr(input logic [15:0] idx);
		return {14'h0000, idx, 2'b00};
	endfunction
endpackage

/* File: rtl/ssf_status_flags.sv */
// Status flags, buffers, slave shifter and APB registers of the serial unit
//
// Behaviour
// - Set overrun flag bit 7 when a character ends while the previous is unread.
// - Writing one to overrun bit clears the overrun flag.
// - Soft reset bit at zero, or system reset, clears overrun and done flags.
// - Overrun raises one interrupt request on each clear-to-set edge only.
// - Overrun and transfer-done requests share one interrupt output.
// - Done flag bit 6 sets at last bit; character loads receive buffer together.
// - Done flag requests interrupt only while operation control bit 0 is one.
// - Reading the receive buffer clears the done flag.
// - Writing the transmit buffer sets the buffer-full flag bit 5.
// - Buffer-full clears when its character moves into the shift register.
// - Buffer-full flag is zero after reset.
// - Writing zero to status bits 5 to 7 changes nothing.
// - Status bits 4 to 0 read zero and ignore writes.
// - Done flag sets and clears whatever its interrupt enable holds.
// - Only an overrun enable of one lets the overrun flag request interrupts.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module ssf_status_flags
	import ssf_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        ce,
	// APB slave
	input  wire logic [31:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial link, slave side
	input  wire logic        link_sclk,
	input  wire logic        link_sdi,
	output logic             link_sdo,
	// Interrupt
	output logic             irq
);

	// Decode of one register index, used by every access path
	function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
		return a == ssf_addr(idx);
	endfunction

	localparam logic [2:0] LAST_BIT = 3'(SSF_CHAR_BITS - 1);

	// Link synchronisers and edge history
	logic [1:0] sclk_sync;
	logic [1:0] sdi_sync;
	logic       sclk_d;

	// Register state
	logic [7:0]              cfg;
	logic [7:0]              opc;
	logic [7:0]              rx_buf;
	logic [7:0]              tx_buf;
	logic                    ovr_flag;
	logic                    xfer_flag;
	logic                    txf_flag;
	logic [SSF_IRQ_BITS-1:0] irq_sts;
	logic [SSF_IRQ_BITS-1:0] irq_msk;
	logic [7:0]              next_cfg;
	logic [7:0]              next_opc;
	logic [7:0]              next_rx_buf;
	logic [7:0]              next_tx_buf;
	logic                    next_ovr_flag;
	logic                    next_xfer_flag;
	logic                    next_txf_flag;
	logic [SSF_IRQ_BITS-1:0] next_irq_sts;
	logic [SSF_IRQ_BITS-1:0] next_irq_msk;

	// Shifter state
	logic [7:0] rx_shift;
	logic [7:0] tx_shift;
	logic [2:0] bit_cnt;
	logic       sdo_q;
	logic [7:0] next_rx_shift;
	logic [7:0] next_tx_shift;
	logic [2:0] next_bit_cnt;
	logic       next_sdo_q;

	// Read data
	logic [31:0] rd_q;
	logic [31:0] next_rd_q;

	// Strobes
	logic sclk_rise;
	logic sclk_fall;
	logic running;
	logic char_done;
	logic setup;
	logic access;
	logic mapped;
	logic wr;
	logic rd_rxb;
	logic ovr_rise;
	logic [7:0] rx_char;
	logic [7:0] sts_val;

	// Link inputs cross into core_clk through two flops before any use
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sclk_sync <= 2'b00;
			sdi_sync  <= 2'b00;
			sclk_d    <= 1'b0;
		end else if (ce) begin
			sclk_sync <= {sclk_sync[0], link_sclk};
			sdi_sync  <= {sdi_sync[0], link_sdi};
			sclk_d    <= sclk_sync[1];
		end
	end

	// Edges compare the second flop with its delayed copy sclk_d
	assign sclk_rise = sclk_sync[1] & ~sclk_d;
	assign sclk_fall = ~sclk_sync[1] & sclk_d;
	assign running   = cfg[SSF_CFG_SRST_BIT];
	assign char_done = running & sclk_rise & (bit_cnt == LAST_BIT);
	assign rx_char   = {rx_shift[6:0], sdi_sync[1]};

	// Bus phases; zero wait states, read data prepared in the setup cycle
	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign mapped  = hit(paddr, SSF_IDX_CFG) | hit(paddr, SSF_IDX_OPC)
		| hit(paddr, SSF_IDX_STS) | hit(paddr, SSF_IDX_RXB)
		| hit(paddr, SSF_IDX_TXB) | hit(paddr, SSF_IDX_IRQ_STS)
		| hit(paddr, SSF_IDX_IRQ_MSK);
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;
	assign wr      = access & pwrite & pstrb[0];
	assign rd_rxb  = access & ~pwrite & hit(paddr, SSF_IDX_RXB);
	assign prdata  = rd_q;

	// Low bits of status always read zero
	assign sts_val = {ovr_flag, xfer_flag, txf_flag, 5'b0_0000};

	// Overrun edge: flag clear now and about to be set
	assign ovr_rise = char_done & xfer_flag & ~ovr_flag;

	// Shifter: sample on rising edge, drive out on falling edge
	always_comb begin
		next_rx_shift = rx_shift;
		next_tx_shift = tx_shift;
		next_bit_cnt  = bit_cnt;
		next_sdo_q    = sdo_q;
		if (!running) begin
			next_bit_cnt  = 3'b000;
			next_tx_shift = SSF_BUF_RST;
			next_sdo_q    = 1'b0;
		end else begin
			if (sclk_rise) begin
				next_rx_shift = rx_char;
				next_bit_cnt  = bit_cnt + 3'b001;
				next_tx_shift = {tx_shift[6:0], 1'b0};
			end
			// Buffered character follows the one just finished
			if (char_done) begin
				next_tx_shift = txf_flag ? tx_buf : SSF_BUF_RST;
			end
			if (sclk_fall) begin
				next_sdo_q = tx_shift[7];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rx_shift <= SSF_BUF_RST;
			tx_shift <= SSF_BUF_RST;
			bit_cnt  <= 3'b000;
			sdo_q    <= 1'b0;
		end else if (ce) begin
			rx_shift <= next_rx_shift;
			tx_shift <= next_tx_shift;
			bit_cnt  <= next_bit_cnt;
			sdo_q    <= next_sdo_q;
		end
	end

	assign link_sdo = sdo_q;

	// Control registers and buffers
	always_comb begin
		next_cfg    = cfg;
		next_opc    = opc;
		next_tx_buf = tx_buf;
		next_irq_msk = irq_msk;
		next_rx_buf = rx_buf;
		if (wr && hit(paddr, SSF_IDX_CFG)) begin
			next_cfg = pwdata[7:0];
		end
		if (wr && hit(paddr, SSF_IDX_OPC)) begin
			next_opc = pwdata[7:0];
		end
		if (wr && hit(paddr, SSF_IDX_TXB)) begin
			next_tx_buf = pwdata[7:0];
		end
		if (wr && hit(paddr, SSF_IDX_IRQ_MSK)) begin
			next_irq_msk = pwdata[SSF_IRQ_BITS-1:0];
		end
		// Character lands in the buffer with the done flag
		if (char_done) begin
			next_rx_buf = rx_char;
		end
	end

	// Status flags; a hardware set always beats a clear in the same cycle
	always_comb begin
		next_ovr_flag  = ovr_flag;
		next_xfer_flag = xfer_flag;
		next_txf_flag  = txf_flag;
		// Only a one clears; zeros and low bits are ignored
		if (wr && hit(paddr, SSF_IDX_STS) && pwdata[SSF_STS_OVR]) begin
			next_ovr_flag = 1'b0;
		end
		if (rd_rxb) begin
			next_xfer_flag = 1'b0;
		end
		if (char_done) begin
			next_txf_flag = 1'b0;
		end
		if (char_done && xfer_flag) begin
			next_ovr_flag = 1'b1;
		end
		// Done flag ignores its interrupt enable
		if (char_done) begin
			next_xfer_flag = 1'b1;
		end
		if (wr && hit(paddr, SSF_IDX_TXB)) begin
			next_txf_flag = 1'b1;
		end
		// Soft reset low holds both receive flags clear
		if (!running) begin
			next_ovr_flag  = 1'b0;
			next_xfer_flag = 1'b0;
		end
	end

	// Sticky interrupt causes, cleared by writing one
	always_comb begin
		next_irq_sts = irq_sts;
		if (wr && hit(paddr, SSF_IDX_IRQ_STS)) begin
			next_irq_sts = irq_sts & ~pwdata[SSF_IRQ_BITS-1:0];
		end
		// One request per overrun edge, enable must read one
		if (ovr_rise && opc[SSF_OPC_OVR_EN] == 1'b1) begin
			next_irq_sts[SSF_IRQ_OVR] = 1'b1;
		end
		// Done cause is set by the flag only while enabled, and stays set after the flag clears
		if (xfer_flag && opc[SSF_OPC_XFER_EN]) begin
			next_irq_sts[SSF_IRQ_XFER] = 1'b1;
		end
	end

	// System reset clears all flags, buffer-full included
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cfg       <= SSF_CFG_RST;
			opc       <= SSF_OPC_RST;
			rx_buf    <= SSF_BUF_RST;
			tx_buf    <= SSF_BUF_RST;
			ovr_flag  <= 1'b0;
			xfer_flag <= 1'b0;
			txf_flag  <= 1'b0;
			irq_sts   <= SSF_ISTS_RST;
			irq_msk   <= SSF_MSK_RST;
		end else if (ce) begin
			cfg       <= next_cfg;
			opc       <= next_opc;
			rx_buf    <= next_rx_buf;
			tx_buf    <= next_tx_buf;
			ovr_flag  <= next_ovr_flag;
			xfer_flag <= next_xfer_flag;
			txf_flag  <= next_txf_flag;
			irq_sts   <= next_irq_sts;
			irq_msk   <= next_irq_msk;
		end
	end

	// Read mux sampled at setup so prdata is a flop in the access cycle
	always_comb begin
		next_rd_q = rd_q;
		if (setup) begin
			next_rd_q = 32'h0000_0000;
			if (hit(paddr, SSF_IDX_CFG)) begin
				next_rd_q[7:0] = cfg;
			end
			if (hit(paddr, SSF_IDX_OPC)) begin
				next_rd_q[7:0] = opc;
			end
			if (hit(paddr, SSF_IDX_STS)) begin
				next_rd_q[7:0] = sts_val;
			end
			if (hit(paddr, SSF_IDX_RXB)) begin
				next_rd_q[7:0] = rx_buf;
			end
			if (hit(paddr, SSF_IDX_TXB)) begin
				next_rd_q[7:0] = tx_buf;
			end
			if (hit(paddr, SSF_IDX_IRQ_STS)) begin
				next_rd_q[SSF_IRQ_BITS-1:0] = irq_sts;
			end
			if (hit(paddr, SSF_IDX_IRQ_MSK)) begin
				next_rd_q[SSF_IRQ_BITS-1:0] = irq_msk;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd_q <= 32'h0000_0000;
		end else if (ce) begin
			rd_q <= next_rd_q;
		end
	end

	// Both causes share the single request line
	assign irq = |(irq_sts & irq_msk);

endmodule

/* File: tb/ssf_status_flags_checker.sv */
// Port checker of the status-flag block
`timescale 1ns/1ps
module ssf_status_flags_checker
	import ssf_pkg::*;
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        srst,
	// Bus
	input wire logic [31:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Link and interrupt
	input wire logic        link_sdo,
	input wire logic        irq
);
	default clocking @(posedge core_clk); endclocking
	// Access phase of a transfer
	wire logic acc;
	assign acc = psel && penable;
	a_ready_zero_wait: assert property (disable iff (srst) acc |-> pready)
		else $error("pready low in access");
	a_err_unmapped: assert property (disable iff (srst) acc && paddr == 32'h0001_C180 |-> pslverr)
		else $error("unmapped access without error");
	a_err_idle: assert property (disable iff (srst) !acc |-> !pslverr)
		else $error("error outside access");
	a_err_mapped: assert property (disable iff (srst) acc &&
		paddr == ssf_addr(SSF_IDX_STS) |-> !pslverr)
		else $error("mapped access with error");
	a_unmapped_rd_zero: assert property (disable iff (srst) acc && !pwrite &&
		paddr == 32'h0001_C180 |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_sts_low_zero: assert property (disable iff (srst) acc && !pwrite &&
		paddr == ssf_addr(SSF_IDX_STS) |-> prdata[4:0] == 5'h00)
		else $error("status low bits not zero");
	a_rd_upper_zero: assert property (disable iff (srst) acc |-> prdata[31:8] == 24'h00_0000)
		else $error("read upper bits not zero");
	a_irq_sys_reset: assert property (srst |=> !irq)
		else $error("interrupt after reset");
	a_prdata_reset: assert property (srst |=> prdata == 32'h0000_0000)
		else $error("read data after reset");
	a_sdo_reset: assert property (srst |=> !link_sdo)
		else $error("serial out after reset");
endmodule

/* File: tb/ssf_link_master.sv */
// Remote serial master model, mode 0, MSB first
`timescale 1ns/1ps
module ssf_link_master (
	// Serial pins
	output logic      sclk,
	output logic      sdi,
	input  wire logic sdo
);
	initial begin
		sclk = 1'b0;
		sdi  = 1'b0;
	end
	// One character; clock stands low between frames
	task automatic send(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sdi = tx[i];
			#62.5 sclk = 1'b1;
			rx[i] = sdo;
			#62.5 sclk = 1'b0;
		end
		sdi = ~sdi; // Released line shows no stale bit
	endtask
endmodule

/* File: tb/ssf_status_flags_tb.sv */
// Self-checking bench of the status-flag block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module ssf_status_flags_tb
	import ssf_pkg::*;
;
	logic        core_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = '0, pwdata = '0, seed = 32'h0000_02dd, e;
	logic [31:0] prdata;
	logic        ce = 1'b1;
	logic [3:0]  pstrb = 4'hF;
	logic        pready, pslverr, link_sclk, link_sdi, link_sdo, irq;
	logic [7:0]  b, t, r;
	int          n_errors = 0, checked = 0, cyc = 0;
	logic [31:0] q[$];
	always #2 core_clk = ~core_clk;
	ssf_status_flags i_dut (.core_clk(core_clk), .srst(srst), .ce(ce), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link_sclk(link_sclk),
		.link_sdi(link_sdi), .link_sdo(link_sdo), .irq(irq));
	ssf_link_master i_lm (.sclk(link_sclk), .sdi(link_sdi), .sdo(link_sdo));
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// One transfer; request held until pready is seen
	task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ssf_addr(i);
		pwdata <= {24'h00_0000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Read with the expected value noted first
	task automatic rd(input logic [15:0] i, input logic [7:0] x);
		q.push_back({24'h00_0000, x});
		bus(1'b0, i, 8'h00);
	endtask
	task automatic wrap_up();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Watcher: oldest note against read data; also hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (psel && penable && pready && !pwrite && q.size() > 0) begin
			e = q.pop_front();
			`CHK("prdata", e, prdata)
		end
		// Hang guard last, so nothing runs after the verdict
		if (cyc == 5000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (4) @(posedge core_clk);
		srst <= 1'b0;
		rd(SSF_IDX_STS, 8'h00);
		rd(SSF_IDX_IRQ_MSK, 8'h03);
		rd(16'h7060, 8'h00);
		bus(1'b1, SSF_IDX_CFG, 8'h80);
		bus(1'b1, SSF_IDX_OPC, 8'h11);
		// Writes without the byte strobe or with the clock enable low must not land
		pstrb <= 4'h0;
		bus(1'b1, SSF_IDX_OPC, 8'h00);
		pstrb <= 4'hF;
		ce <= 1'b0;
		bus(1'b1, SSF_IDX_OPC, 8'h00);
		ce <= 1'b1;
		rd(SSF_IDX_OPC, 8'h11);
		t = xs();
		bus(1'b1, SSF_IDX_TXB, t);
		rd(SSF_IDX_STS, 8'h20);
		bus(1'b1, SSF_IDX_STS, 8'h1F);
		rd(SSF_IDX_STS, 8'h20);
		i_lm.send(xs(), r);
		rd(SSF_IDX_STS, 8'h40);
		rd(SSF_IDX_IRQ_STS, 8'h01);
		`CHK("irq", 1'b1, irq)
		b = xs();
		i_lm.send(b, r);
		`CHK("sdo char", t, r)
		rd(SSF_IDX_STS, 8'hC0);
		rd(SSF_IDX_IRQ_STS, 8'h03);
		rd(SSF_IDX_RXB, b);
		rd(SSF_IDX_STS, 8'h80);
		bus(1'b1, SSF_IDX_IRQ_STS, 8'h03);
		rd(SSF_IDX_IRQ_STS, 8'h00);
		`CHK("irq", 1'b0, irq)
		i_lm.send(xs(), r);
		// Second overrun while the flag is still set asks for nothing new
		i_lm.send(xs(), r);
		rd(SSF_IDX_IRQ_STS, 8'h01);
		rd(SSF_IDX_STS, 8'hC0);
		bus(1'b1, SSF_IDX_STS, 8'h80);
		rd(SSF_IDX_STS, 8'h40);
		bus(1'b1, SSF_IDX_IRQ_MSK, 8'h00);
		rd(SSF_IDX_IRQ_MSK, 8'h00);
		`CHK("irq", 1'b0, irq)
		bus(1'b1, SSF_IDX_IRQ_MSK, 8'h03);
		bus(1'b1, SSF_IDX_CFG, 8'h00);
		rd(SSF_IDX_STS, 8'h00);
		bus(1'b1, SSF_IDX_CFG, 8'h80);
		bus(1'b1, SSF_IDX_OPC, 8'h00);
		bus(1'b1, SSF_IDX_IRQ_STS, 8'h03);
		i_lm.send(xs(), r);
		rd(SSF_IDX_STS, 8'h40);
		i_lm.send(xs(), r);
		rd(SSF_IDX_STS, 8'hC0);
		rd(SSF_IDX_IRQ_STS, 8'h00);
		`CHK("irq", 1'b0, irq)
		// Mid-run system reset with every flag set
		bus(1'b1, SSF_IDX_TXB, xs());
		rd(SSF_IDX_STS, 8'hE0);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rd(SSF_IDX_STS, 8'h00);
		rd(SSF_IDX_OPC, 8'h00);
		rd(SSF_IDX_IRQ_MSK, 8'h03);
		// Let the watcher take the last note before counting leftovers
		@(posedge core_clk);
		`CHK("notes left", 32'h0000_0000, 32'(q.size()))
		wrap_up();
	end
endmodule
bind ssf_status_flags ssf_status_flags_checker i_chk (.core_clk(core_clk), .srst(srst),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .link_sdo(link_sdo), .irq(irq));
